// File: ata_write_cmds.sv
// Task-file write command interpreter: extended DMA write, multiple write and
// extended multiple write, with AHB-Lite register access and a media commit port.
// Assumes DMA pins synchronous to CLK and a media side that commits one sector per
// handshake and reads the sector buffer by word address while MEDIA_VALID is high.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module ata_write_cmds #(
  parameter int MULT_BLOCK = 1,
  parameter int WORDS = ata_wr_pkg::SECTOR_WORDS
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic DMARQ,
  input wire logic DMACK_B,
  input wire logic IOWR_B,
  input wire logic [15:0] DD,
  output logic INTRQ,
  output logic MEDIA_VALID,
  output logic [47:0] MEDIA_LBA,
  input wire logic MEDIA_READY,
  input wire logic MEDIA_FAIL,
  input wire logic [7:0] MEDIA_RADDR,
  output logic [15:0] MEDIA_RDATA
);

  // Block size above one would need per-block counting; not offered
  if (MULT_BLOCK != 1) begin : g_bad_block
    $error("only a multiple-write block size of one is supported");
  end
  if (WORDS != 256) begin : g_bad_words
    $error("sector must be 256 words");
  end
  if (ata_wr_pkg::BSY_MAX_CYC < 1) begin : g_bad_bsy
    $error("busy deadline shorter than one clock");
  end

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_SETUP = 4'b0010,
    S_XFER = 4'b0100,
    S_COMMIT = 4'b1000
  } state_t;

  typedef struct packed {
    state_t st;
    logic [7:0] cmd;
    logic ext;
    logic dma;
    logic [15:0] feat;
    logic [15:0] cnt;
    logic [15:0] lbal;
    logic [15:0] lbam;
    logic [15:0] lbah;
    logic [7:0] devsel;
    logic hob;
    logic [2:0] cfg;
    logic [7:0] err;
    logic bsy;
    logic drq;
    logic errst;
    logic intrq;
    logic [47:0] lba;
    logic [16:0] remain;
    logic [7:0] wcnt;
    logic iowr_q;
    logic mem_we;
    logic [7:0] mem_wa;
    logic [15:0] mem_wd;
    logic dph_v;
    logic dph_w;
    logic [5:0] dph_a;
    logic rd_ok;
    logic [31:0] rdata;
    logic media_v;
  } regs_t;

  regs_t r_reg;
  regs_t r_next;
  logic hready_int;
  logic word_strobe;
  logic [15:0] word_data;
  logic [47:0] tf_lba;

  // Task-file image {high, mid, low} of an address, previous byte in [15:8]
  function automatic logic [47:0] pack_lba(input logic ext, input logic [47:0] a);
    if (ext) begin
      pack_lba = {a[47:40], a[23:16], a[39:32], a[15:8], a[31:24], a[7:0]};
    end else begin
      pack_lba = {8'h00, a[23:16], 8'h00, a[15:8], 8'h00, a[7:0]};
    end
  endfunction : pack_lba

  function automatic logic [7:0] pick(input logic hob, input logic [15:0] f);
    pick = hob ? f[15:8] : f[7:0];  // see R19
  endfunction : pick

  sector_buffer #(
    .WIDTH(16),
    .DEPTH(WORDS),
    .AW(8)
  ) u_buf (
    .clk(CLK),
    .wr_en(r_reg.mem_we),
    .wr_addr(r_reg.mem_wa),
    .wr_data(r_reg.mem_wd),
    .rd_addr(MEDIA_RADDR),
    .rd_data(MEDIA_RDATA)
  );

  // Reads take one wait state so a write just ahead is always visible
  assign hready_int = !(r_reg.dph_v && !r_reg.dph_w && !r_reg.rd_ok);
  assign HREADYOUT = hready_int;
  assign HRESP = 1'b0;
  assign HRDATA = r_reg.rdata;
  assign DMARQ = (r_reg.st == S_XFER) && r_reg.dma;  // see R3
  assign INTRQ = r_reg.intrq;
  assign MEDIA_VALID = r_reg.media_v;
  assign MEDIA_LBA = r_reg.lba;

  always_comb begin
    word_strobe = 1'b0;
    word_data = DD;
    if (r_reg.st == S_XFER) begin
      if (r_reg.dma) begin
        // Falling edge of the write strobe under acknowledge is one word
        word_strobe = !DMACK_B && r_reg.iowr_q && !IOWR_B;  // see R4
      end else if (r_reg.dph_v && r_reg.dph_w && r_reg.dph_a == ata_wr_pkg::A_DATA) begin
        word_strobe = 1'b1;
        word_data = HWDATA[15:0];
      end
    end
  end

  always_comb begin
    r_next = r_reg;
    tf_lba = pack_lba(r_reg.ext, r_reg.lba);
    r_next.iowr_q = IOWR_B;
    r_next.mem_we = 1'b0;

    // Address phase
    if (HREADY) begin
      r_next.dph_v = HSEL && HTRANS[1] && (HADDR[31:6] == 26'h0);
      r_next.dph_w = HWRITE;
      r_next.dph_a = HADDR[5:0];
      r_next.rd_ok = 1'b0;
    end

    // Read data phase, with its side effects
    if (r_reg.dph_v && !r_reg.dph_w && !r_reg.rd_ok) begin
      r_next.rd_ok = 1'b1;
      r_next.rdata = 32'h0000_0000;
      case (r_reg.dph_a)
        ata_wr_pkg::A_FEAT: r_next.rdata[7:0] = r_reg.err;
        ata_wr_pkg::A_CNT: r_next.rdata[7:0] = pick(r_reg.hob, r_reg.cnt);
        ata_wr_pkg::A_LBAL: r_next.rdata[7:0] = pick(r_reg.hob, r_reg.lbal);
        ata_wr_pkg::A_LBAM: r_next.rdata[7:0] = pick(r_reg.hob, r_reg.lbam);
        ata_wr_pkg::A_LBAH: r_next.rdata[7:0] = pick(r_reg.hob, r_reg.lbah);
        ata_wr_pkg::A_DEVSEL: begin
          if (r_reg.ext) begin
            r_next.rdata[7:0] = {ata_wr_pkg::DEVSEL_ONES, r_reg.devsel[4:0]};  // see R21
          end else begin
            r_next.rdata[7:0] = r_reg.devsel;
          end
        end
        ata_wr_pkg::A_CMD, ata_wr_pkg::A_ALTSTAT: begin
          r_next.rdata[ata_wr_pkg::ST_BSY] = r_reg.bsy;
          r_next.rdata[ata_wr_pkg::ST_DRDY] = 1'b1;
          r_next.rdata[ata_wr_pkg::ST_DRQ] = r_reg.drq;
          r_next.rdata[ata_wr_pkg::ST_ERR] = r_reg.errst;
        end
        ata_wr_pkg::A_DEVCTL: r_next.rdata[ata_wr_pkg::HOB_BIT] = r_reg.hob;
        ata_wr_pkg::A_CFG: r_next.rdata[2:0] = r_reg.cfg;
        ata_wr_pkg::A_IDENT: r_next.rdata[15:0] = ata_wr_pkg::MULT_MAX;  // see R17
        default: r_next.rdata = 32'h0000_0000;
      endcase
      if (r_reg.dph_a <= ata_wr_pkg::A_CMD) begin
        r_next.hob = 1'b0;  // see R19
      end
      // Reading the primary status acknowledges the interrupt
      if (r_reg.dph_a == ata_wr_pkg::A_CMD) begin
        r_next.intrq = 1'b0;
      end
    end

    // Write data phase; task file is locked while a command runs
    if (r_reg.dph_v && r_reg.dph_w) begin
      if (r_reg.dph_a <= ata_wr_pkg::A_CMD) begin
        r_next.hob = 1'b0;  // see R19
      end
      case (r_reg.dph_a)
        ata_wr_pkg::A_DEVCTL: r_next.hob = HWDATA[ata_wr_pkg::HOB_BIT];
        ata_wr_pkg::A_CFG: r_next.cfg = HWDATA[2:0];
        default: begin
          if (r_reg.st == S_IDLE) begin
            case (r_reg.dph_a)
              // Each 16-bit field shifts its current byte into the previous byte; device select is written whole
              ata_wr_pkg::A_FEAT: r_next.feat = {r_reg.feat[7:0], HWDATA[7:0]};
              ata_wr_pkg::A_CNT: r_next.cnt = {r_reg.cnt[7:0], HWDATA[7:0]};  // see R21
              ata_wr_pkg::A_LBAL: r_next.lbal = {r_reg.lbal[7:0], HWDATA[7:0]};
              ata_wr_pkg::A_LBAM: r_next.lbam = {r_reg.lbam[7:0], HWDATA[7:0]};
              ata_wr_pkg::A_LBAH: r_next.lbah = {r_reg.lbah[7:0], HWDATA[7:0]};
              ata_wr_pkg::A_DEVSEL: r_next.devsel = HWDATA[7:0];
              ata_wr_pkg::A_CMD: begin
                r_next.cmd = HWDATA[7:0];
                r_next.st = S_SETUP;
                r_next.bsy = 1'b1;  // see R2 R10
                r_next.drq = 1'b0;
                r_next.errst = 1'b0;
                r_next.err = 8'h00;
                r_next.intrq = 1'b0;
              end
              default: r_next.st = r_reg.st;
            endcase
          end
        end
      endcase
    end

    case (r_reg.st)
      S_IDLE: r_next.media_v = 1'b0;
      S_SETUP: begin
        r_next.ext = (r_reg.cmd != ata_wr_pkg::OP_WR_MULT);  // see R18
        r_next.dma = (r_reg.cmd == ata_wr_pkg::OP_WR_DMA_EXT);  // see R9
        r_next.wcnt = 8'h00;
        if (r_reg.cmd == ata_wr_pkg::OP_WR_MULT) begin
          r_next.lba = {20'h00000, r_reg.devsel[3:0], r_reg.lbah[7:0], r_reg.lbam[7:0],
                        r_reg.lbal[7:0]};
          // Count is sectors; a block of one makes every block full
          r_next.remain = (r_reg.cnt[7:0] == 8'h00) ? ata_wr_pkg::CNT28_ZERO :
                          {9'h000, r_reg.cnt[7:0]};  // see R12
        end else begin
          r_next.lba = {r_reg.lbah[15:8], r_reg.lbam[15:8], r_reg.lbal[15:8],
                        r_reg.lbah[7:0], r_reg.lbam[7:0], r_reg.lbal[7:0]};  // see R18
          r_next.remain = (r_reg.cnt == 16'h0000) ? ata_wr_pkg::CNT48_ZERO :
                          {1'b0, r_reg.cnt};  // see R1
        end
        if ((r_reg.cmd == ata_wr_pkg::OP_WR_DMA_EXT && r_reg.cfg[ata_wr_pkg::CFG_EIGHT_BIT])
            || ((r_reg.cmd == ata_wr_pkg::OP_WR_MULT
                 || r_reg.cmd == ata_wr_pkg::OP_WR_MULT_EXT)
                && (!r_reg.cfg[ata_wr_pkg::CFG_MULT_SET]
                    || r_reg.cfg[ata_wr_pkg::CFG_MULT_OFF]))
            || (r_reg.cmd == ata_wr_pkg::OP_WR_MULT && !r_reg.devsel[ata_wr_pkg::DEV_LBA_BIT])
            || (r_reg.cmd != ata_wr_pkg::OP_WR_MULT && r_reg.cmd != ata_wr_pkg::OP_WR_MULT_EXT
                && r_reg.cmd != ata_wr_pkg::OP_WR_DMA_EXT)) begin
          r_next.st = S_IDLE;  // see R8 R13
          r_next.bsy = 1'b0;
          r_next.errst = 1'b1;
          r_next.err[ata_wr_pkg::ER_ABRT] = 1'b1;
          r_next.intrq = 1'b1;
        end else begin
          r_next.st = S_XFER;
          r_next.bsy = 1'b0;  // see R2 R22
          r_next.drq = 1'b1;
          // Block start interrupt only for multiple writes
          r_next.intrq = (r_reg.cmd != ata_wr_pkg::OP_WR_DMA_EXT);  // see R15 R5
        end
      end
      S_XFER: begin
        if (word_strobe) begin
          r_next.mem_we = 1'b1;
          r_next.mem_wa = r_reg.wcnt;
          r_next.mem_wd = word_data;
          r_next.wcnt = r_reg.wcnt + 8'h01;
          if (r_reg.wcnt == 8'(WORDS - 1)) begin
            // No per-sector interrupt: busy covers the commit
            r_next.st = S_COMMIT;  // see R11
            r_next.bsy = 1'b1;
            r_next.drq = 1'b0;
            r_next.media_v = 1'b1;
          end
        end
      end
      S_COMMIT: begin
        if (MEDIA_READY) begin
          r_next.media_v = 1'b0;
          if (MEDIA_FAIL) begin
            // Stop at the failing sector, report it, send nothing more
            r_next.st = S_IDLE;  // see R7 R14
            {r_next.lbah, r_next.lbam, r_next.lbal} = tf_lba;  // see R7 R16 R20
            if (!r_reg.ext) begin
              r_next.devsel[3:0] = r_reg.lba[27:24];
            end
            if (!r_reg.dma) begin
              r_next.cnt = r_reg.remain[15:0];  // see R16 R20
            end
            r_next.bsy = 1'b0;
            r_next.errst = 1'b1;
            r_next.err[ata_wr_pkg::ER_MEDIA] = 1'b1;
            r_next.intrq = 1'b1;  // see R5
          end else if (r_reg.remain == 17'h00001) begin
            r_next.st = S_IDLE;
            {r_next.lbah, r_next.lbam, r_next.lbal} = tf_lba;  // see R6
            if (!r_reg.ext) begin
              r_next.devsel[3:0] = r_reg.lba[27:24];
            end
            r_next.cnt = 16'h0000;
            r_next.remain = 17'h00000;
            r_next.bsy = 1'b0;
            r_next.intrq = 1'b1;  // see R5
          end else begin
            r_next.st = S_XFER;
            r_next.remain = r_reg.remain - 17'h00001;
            r_next.lba = r_reg.lba + 48'h1;
            r_next.wcnt = 8'h00;
            r_next.bsy = 1'b0;
            r_next.drq = 1'b1;
            r_next.intrq = !r_reg.dma;  // see R15 R5
          end
        end
      end
      default: begin
        r_next.st = S_IDLE;
        r_next.bsy = 1'b0;
        r_next.drq = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      r_reg <= '0;
      r_reg.st <= S_IDLE;
      r_reg.cfg <= ata_wr_pkg::CFG_RESET;
      r_reg.iowr_q <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule : ata_write_cmds

// File: ata_wr_pkg.sv
// Constants for the task-file write command interpreter: register offsets on the
// AHB-Lite slave, opcodes, status and error bit positions, and timing figures.
// Assumes a 100 MHz clock; all users name constants as ata_wr_pkg::name.
// Contract
// R1 - Extended DMA write moves 1 to 65536 sectors; zero count means 65536.
// R2 - DMA write sets busy first, then may raise data request and drop busy.
// R3 - DMA request stays high while the device can accept write data.
// R4 - Host acknowledges and strobes one 16-bit word per write pulse, 512 bytes/sector.
// R5 - DMA write interrupts only at full completion or unrecoverable error.
// R6 - Successful DMA write leaves last written sector address in task file.
// R7 - Failed DMA write stops at failing sector and reports its address.
// R8 - DMA write aborts when 8-bit transfer mode is enabled.
// R9 - Opcode 35h is the 48-bit DMA write.
// R10 - Opcode C5h is multiple write; busy set within 400 ns.
// R11 - Multiple write moves a block without interrupts; data request per block.
// R12 - Count is sectors; full blocks then one partial block of the remainder.
// R13 - Multiple write aborts if block size unset or multiple writes disabled.
// R14 - Multiple write error posted after block; ends at failing sector.
// R15 - Multiple write interrupts whenever data request rises at block start.
// R16 - After multiple write error, address is failing sector, count is residual.
// R17 - Only block size one is supported and reported in identify data.
// R18 - Opcode 39h needs LBA, 48-bit address and 16-bit count.
// R19 - High-order byte select reads previous byte; any task-file access clears it.
// R20 - Extended multiple write error reports 48-bit address and 16-bit residual.
// R21 - Device select reads ones in bits 7..5, drive in bit 4; here only after a command other than C5h, as written after reset or C5h.
// R22 - Sector write raises data request and drops busy without first interrupt.
package ata_wr_pkg;

  // Register byte offsets, all one aligned word each
  localparam logic [5:0] A_DATA = 6'h00;
  localparam logic [5:0] A_FEAT = 6'h04;
  localparam logic [5:0] A_CNT = 6'h08;
  localparam logic [5:0] A_LBAL = 6'h0C;
  localparam logic [5:0] A_LBAM = 6'h10;
  localparam logic [5:0] A_LBAH = 6'h14;
  localparam logic [5:0] A_DEVSEL = 6'h18;
  localparam logic [5:0] A_CMD = 6'h1C;
  localparam logic [5:0] A_DEVCTL = 6'h20;
  localparam logic [5:0] A_CFG = 6'h24;
  localparam logic [5:0] A_IDENT = 6'h28;
  localparam logic [5:0] A_ALTSTAT = 6'h2C;

  localparam logic [7:0] OP_WR_DMA_EXT = 8'h35;
  localparam logic [7:0] OP_WR_MULT = 8'hC5;
  localparam logic [7:0] OP_WR_MULT_EXT = 8'h39;

  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT = 2;
  localparam int ER_MEDIA = 6;
  localparam int HOB_BIT = 7;
  localparam int DEV_LBA_BIT = 6;
  localparam logic [2:0] DEVSEL_ONES = 3'h7;

  // Configuration bits
  localparam int CFG_EIGHT_BIT = 0;
  localparam int CFG_MULT_OFF = 1;
  localparam int CFG_MULT_SET = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;

  localparam logic [15:0] MULT_MAX = 16'h0001;
  localparam int SECTOR_WORDS = 256;
  localparam logic [16:0] CNT28_ZERO = 17'h00100;
  localparam logic [16:0] CNT48_ZERO = 17'h10000;

  localparam int CLK_NS = 10;
  localparam int BSY_MAX_NS = 400;
  localparam int BSY_MAX_CYC = BSY_MAX_NS / CLK_NS;

endpackage : ata_wr_pkg

// File: sector_buffer.sv
// One-sector word buffer between the host data port and the media.
// Assumes one writer and one reader that never overlap within a sector.
`timescale 1ns/10ps
module sector_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("sector_buffer depth exceeds address range");
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : sector_buffer

// File: ata_wr_asserts.sv
// Port checker for the task-file write command interpreter.
// Assumes binding onto ata_write_cmds; sees its ports only.
`timescale 1ns/10ps
module ata_wr_asserts #(
  parameter int WORDS = 256
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic DMARQ,
  input wire logic DMACK_B,
  input wire logic IOWR_B,
  input wire logic INTRQ,
  input wire logic MEDIA_VALID,
  input wire logic [47:0] MEDIA_LBA,
  input wire logic MEDIA_READY
);
  logic iowr_q;
  logic [8:0] words;
  logic take;
  logic req;
  logic last;
  assign take = DMARQ && !DMACK_B && !IOWR_B && iowr_q;
  assign req = HSEL && HTRANS[1] && HREADY;
  assign last = words == 9'(WORDS - 1);
  // Own word count, wraps at each whole sector
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      iowr_q <= 1'b1;
      words <= 9'h000;
    end else begin
      iowr_q <= IOWR_B;
      if (take) begin
        words <= last ? 9'h000 : words + 9'h001;
      end
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_rq_holds_mid: assert property (take && !last |=> DMARQ)
    else $error("request dropped inside a sector");
  a_rq_drop_full: assert property (take && last |=> !DMARQ)
    else $error("request kept after a full sector");
  a_rq_starts_whole: assert property ($rose(DMARQ) |-> words == 9'h000)
    else $error("request resumed mid sector");
  a_commit_quiet: assert property (MEDIA_VALID |-> !DMARQ)
    else $error("request high during commit");
  a_no_sector_irq: assert property ($rose(INTRQ) |-> !DMARQ)
    else $error("interrupt during data transfer");
  a_commit_holds: assert property (MEDIA_VALID && !MEDIA_READY |=> MEDIA_VALID && $stable(MEDIA_LBA))
    else $error("commit changed before accept");
  a_commit_ends: assert property (MEDIA_VALID && MEDIA_READY |=> !MEDIA_VALID)
    else $error("commit not retired");
  a_read_wait: assert property (req && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  a_write_nowait: assert property (req && HWRITE |=> HREADYOUT)
    else $error("write stalled");
  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("response not okay");
  c_take: cover property (take && last);
  c_commit: cover property (MEDIA_VALID && MEDIA_READY);
  c_irq: cover property ($rose(INTRQ));
endmodule : ata_wr_asserts

bind ata_write_cmds ata_wr_asserts #(.WORDS(WORDS)) chk_i (.CLK(CLK), .RST_B(RST_B),
  .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .DMARQ(DMARQ), .DMACK_B(DMACK_B), .IOWR_B(IOWR_B), .INTRQ(INTRQ),
  .MEDIA_VALID(MEDIA_VALID), .MEDIA_LBA(MEDIA_LBA), .MEDIA_READY(MEDIA_READY));

// File: dma_host_model.sv
// Host DMA engine model: acknowledges and strobes one word per pulse.
// Assumes device request synchronous to CLK; slow adds idle gaps.
`timescale 1ns/10ps
module dma_host_model (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic DMARQ,
  input wire logic slow,
  output logic DMACK_B,
  output logic IOWR_B,
  output logic [15:0] DD
);
  logic [1:0] gap;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      DMACK_B <= 1'b1;
      IOWR_B <= 1'b1;
      DD <= 16'h0000;
      gap <= 2'h0;
    end else if (DMARQ) begin
      DMACK_B <= 1'b0;
      if (!IOWR_B) begin
        IOWR_B <= 1'b1;
      end else if (gap != 2'h0) begin
        gap <= gap - 2'h1;
      end else begin
        IOWR_B <= 1'b0;
        DD <= DD + 16'h1357;
        gap <= {slow, slow};
      end
    end else begin
      DMACK_B <= 1'b1;
      IOWR_B <= 1'b1;
      // Released bus must not look like the last word
      DD <= ~DD;
    end
  end
endmodule : dma_host_model

// File: ata_write_dma_multiple_cmds_bench.sv
// Bench for the write command interpreter: bus tasks, host DMA model, media responder.
// Assumes the design answers reads after one wait state and writes at once.
`timescale 1ns/10ps
module ata_write_dma_multiple_cmds_bench;
  logic CLK = 1'b0;
  logic RST_B, HSEL, HWRITE, HREADYOUT, HRESP, DMARQ, DMACK_B, IOWR_B, INTRQ;
  logic MEDIA_VALID, slow;
  logic MEDIA_READY = 1'b0;
  logic MEDIA_FAIL = 1'b0;
  logic irq_q = 1'b0;
  logic [1:0] HTRANS;
  logic [31:0] HADDR, HWDATA, HRDATA, q;
  logic [15:0] DD, MEDIA_RDATA;
  logic [47:0] MEDIA_LBA, fail_lba;
  logic [7:0] st;
  int failures, samples_checked, cycles, commits, irq_rises;
  logic [7:0] ab_op [4] = '{ata_wr_pkg::OP_WR_DMA_EXT, ata_wr_pkg::OP_WR_MULT,
    ata_wr_pkg::OP_WR_MULT, ata_wr_pkg::OP_WR_MULT_EXT};
  logic [2:0] ab_cfg [4] = '{3'h1, 3'h0, 3'h6, 3'h2};

  ata_write_cmds uut (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DMARQ(DMARQ),
    .DMACK_B(DMACK_B), .IOWR_B(IOWR_B), .DD(DD), .INTRQ(INTRQ),
    .MEDIA_VALID(MEDIA_VALID), .MEDIA_LBA(MEDIA_LBA), .MEDIA_READY(MEDIA_READY),
    .MEDIA_FAIL(MEDIA_FAIL), .MEDIA_RADDR(8'h00), .MEDIA_RDATA(MEDIA_RDATA));
  dma_host_model host (.CLK(CLK), .RST_B(RST_B), .DMARQ(DMARQ), .slow(slow),
    .DMACK_B(DMACK_B), .IOWR_B(IOWR_B), .DD(DD));

  always #5 CLK = ~CLK;

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // Media accepts one cycle after each commit; fails only at fail_lba
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    irq_q <= INTRQ;
    MEDIA_READY <= MEDIA_VALID && !MEDIA_READY;
    MEDIA_FAIL <= MEDIA_VALID && MEDIA_LBA == fail_lba;
    if (MEDIA_VALID && MEDIA_READY) commits++;
    if (INTRQ && !irq_q) irq_rises++;
    if (cycles == 40000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HADDR <= {26'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask : bus

  task automatic wb(input logic [5:0] a, input logic [7:0] b);
    bus(1'b1, a, {24'h0, b});
  endtask : wb

  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd

  // Previous byte first, then current, for the count and the three address fields
  task automatic issue(input logic [7:0] op, input logic [47:0] lba, input logic [15:0] n);
    wb(ata_wr_pkg::A_CNT, n[15:8]);
    wb(ata_wr_pkg::A_CNT, n[7:0]);
    wb(ata_wr_pkg::A_LBAL, lba[31:24]);
    wb(ata_wr_pkg::A_LBAL, lba[7:0]);
    wb(ata_wr_pkg::A_LBAM, lba[39:32]);
    wb(ata_wr_pkg::A_LBAM, lba[15:8]);
    wb(ata_wr_pkg::A_LBAH, lba[47:40]);
    wb(ata_wr_pkg::A_LBAH, lba[23:16]);
    wb(ata_wr_pkg::A_DEVSEL, 8'hE0);
    irq_rises = 0;
    commits = 0;
    wb(ata_wr_pkg::A_CMD, op);
  endtask : issue

  // Alternate status keeps the interrupt pending while polling
  task automatic poll;
    do begin
      rd(ata_wr_pkg::A_ALTSTAT);
      st = q[7:0];
    end while (st[ata_wr_pkg::ST_BSY]);
  endtask : poll

  task automatic pio(input int n);
    for (int i = 0; i < n; i++) begin
      poll();
      if (st[ata_wr_pkg::ST_ERR]) break;
      chk("block drq", {31'h0, st[ata_wr_pkg::ST_DRQ]}, 32'h1);
      chk("block irq", {31'h0, INTRQ}, 32'h1);
      rd(ata_wr_pkg::A_CMD);
      repeat (ata_wr_pkg::SECTOR_WORDS) bus(1'b1, ata_wr_pkg::A_DATA, 32'h0000A55A);
    end
    poll();
  endtask : pio

  initial begin
    RST_B = 1'b0;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HWDATA = 32'h0;
    slow = 1'b1;
    fail_lba = 48'hFFFFFFFFFFFF;
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    rd(ata_wr_pkg::A_IDENT);
    chk("ident", q, {16'h0, ata_wr_pkg::MULT_MAX});
    rd(ata_wr_pkg::A_ALTSTAT);
    chk("idle status", q, 32'h40);
    rd(6'h3C);
    chk("unmapped", q, 32'h0);
    wb(ata_wr_pkg::A_DEVSEL, 8'h10);
    rd(ata_wr_pkg::A_DEVSEL);
    chk("devsel raw", q, 32'h10);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wb(ata_wr_pkg::A_CFG, {5'h0, ab_cfg[i]});
      issue(ab_op[i], 48'h1, 16'h1);
      poll();
      chk("abort status", {24'h0, st}, 32'h41);
      rd(ata_wr_pkg::A_FEAT);
      chk("abort error", q, 32'h1 << ata_wr_pkg::ER_ABRT);
      rd(ata_wr_pkg::A_CMD);
    end
    $display("test aborts done");
    wb(ata_wr_pkg::A_CFG, 8'h00);
    issue(ata_wr_pkg::OP_WR_DMA_EXT, 48'hA1B2C3D4E5F6, 16'h2);
    rd(ata_wr_pkg::A_ALTSTAT);
    chk("busy or drq", {31'h0, q[7] | q[3]}, 32'h1);
    while (INTRQ !== 1'b1) @(posedge CLK);
    chk("dma commits", commits, 2);
    rd(ata_wr_pkg::A_CMD);
    chk("dma status", q, 32'h40);
    chk("dma irqs", irq_rises, 1);
    rd(ata_wr_pkg::A_LBAL);
    chk("last lba", q, 32'hF7);
    wb(ata_wr_pkg::A_DEVCTL, 8'h80);
    rd(ata_wr_pkg::A_LBAL);
    chk("hob byte", q, 32'hC3);
    rd(ata_wr_pkg::A_LBAL);
    chk("hob cleared", q, 32'hF7);
    wb(ata_wr_pkg::A_DEVSEL, 8'h10);
    rd(ata_wr_pkg::A_DEVSEL);
    chk("devsel ext", q, 32'hF0);
    $display("test dma done");
    slow = 1'b0;
    fail_lba = 48'h11;
    issue(ata_wr_pkg::OP_WR_DMA_EXT, 48'h10, 16'h0);
    while (INTRQ !== 1'b1) @(posedge CLK);
    chk("fail commits", commits, 2);
    rd(ata_wr_pkg::A_CMD);
    chk("fail status", q, 32'h41);
    rd(ata_wr_pkg::A_FEAT);
    chk("media error", q, 32'h1 << ata_wr_pkg::ER_MEDIA);
    rd(ata_wr_pkg::A_LBAL);
    chk("fail lba", q, 32'h11);
    $display("test dma error done");
    wb(ata_wr_pkg::A_CFG, 8'h04);
    fail_lba = 48'h7E0000000021;
    issue(ata_wr_pkg::OP_WR_MULT_EXT, 48'h7E0000000020, 16'h3);
    pio(3);
    chk("mult commits", commits, 2);
    chk("mult status", {24'h0, st}, 32'h41);
    rd(ata_wr_pkg::A_CNT);
    chk("residual", q, 32'h2);
    rd(ata_wr_pkg::A_LBAL);
    chk("mult fail lba", q, 32'h21);
    wb(ata_wr_pkg::A_DEVCTL, 8'h80);
    rd(ata_wr_pkg::A_LBAH);
    chk("lba 47:40", q, 32'h7E);
    wb(ata_wr_pkg::A_DEVCTL, 8'h80);
    rd(ata_wr_pkg::A_CNT);
    chk("residual high", q, 32'h0);
    rd(ata_wr_pkg::A_CMD);
    $display("test mult error done");
    issue(ata_wr_pkg::OP_WR_MULT, 48'h30, 16'h2);
    pio(2);
    chk("mult done", {24'h0, st}, 32'h40);
    chk("mult count", commits, 2);
    rd(ata_wr_pkg::A_LBAL);
    chk("mult last lba", q, 32'h31);
    chk("buffer word", {16'h0, MEDIA_RDATA}, 32'hA55A);
    $display("test mult done");
    close_out();
  end
endmodule : ata_write_dma_multiple_cmds_bench
